// File: design/tplf_defines.svh
// Register offsets, field positions, reset values and fixed sizes of the
// transport parameter lock and container format control block.
// Assumes a 32-bit APB with byte addresses, one aligned word per register.
`ifndef TPLF_DEFINES_SVH
`define TPLF_DEFINES_SVH

`define TPLF_OFF_LOCK       8'h00
`define TPLF_OFF_GRP_SEL    8'h04
`define TPLF_OFF_GRP_STATE  8'h08
`define TPLF_OFF_WIDTH      8'h0c
`define TPLF_OFF_HEIGHT     8'h10
`define TPLF_OFF_PIX_FMT    8'h14
`define TPLF_OFF_CFG        8'h18
`define TPLF_OFF_CHAN_IDX   8'h1c
`define TPLF_OFF_BYTE_CNT   8'h20
`define TPLF_OFF_FMT_STAT   8'h24
`define TPLF_OFF_HDR_IDX    8'h28
`define TPLF_OFF_HDR_DATA   8'h2c
`define TPLF_OFF_CMD        8'h30
`define TPLF_OFF_STATUS     8'h34

`define TPLF_PIX_BPP_LSB    8
`define TPLF_CFG_LINE_SCAN  0
`define TPLF_CFG_LONG_PL    1
`define TPLF_CFG_MODE_LSB   4
`define TPLF_CFG_TEST_LSB   6
`define TPLF_CFG_HDR_VAR    8
`define TPLF_CMD_CAPTURE    0
`define TPLF_CMD_TRANSFER   1
`define TPLF_CMD_STOP       2

`define TPLF_RST_WIDTH      16'h0280
`define TPLF_RST_HEIGHT     16'h01e0
`define TPLF_RST_PIX_FMT    12'h101
`define TPLF_RST_GRP_STATE  5'h1f

`define TPLF_TRAILER_BYTES  32'h0000_0040
`define TPLF_LONG_BYTES     32'h0000_0400
`define TPLF_HDR_BYTES      32'h0000_0080
`define TPLF_META_BYTES     32'h0000_0100
`define TPLF_HDR_VERSION    16'h0100

`endif

// File: design/tplf_pkg.sv
// Types shared by the transport parameter lock and format control block.
// Assumes the defines header is compiled alongside.
package tplf_pkg;
	typedef enum logic [2:0] {
		TPLF_GRP_FRAME_DIM = 3'h0,
		TPLF_GRP_PIX_ENC   = 3'h1,
		TPLF_GRP_PIX_WIDTH = 3'h2,
		TPLF_GRP_LONG_PL   = 3'h3,
		TPLF_GRP_DEV_SPEC  = 3'h4
	} tplf_group_t;

	typedef enum logic [1:0] {
		TPLF_FMT_OFF  = 2'h0,
		TPLF_FMT_ON   = 2'h1,
		TPLF_FMT_AUTO = 2'h2
	} tplf_fmt_mode_t;

	typedef enum logic [1:0] {
		TPLF_TEST_OFF       = 2'h0,
		TPLF_TEST_MULTIPART = 2'h1,
		TPLF_TEST_CONTAINER = 2'h2
	} tplf_test_sel_t;

	typedef enum logic [2:0] {
		TPLF_ACQ_IDLE      = 3'b001,
		TPLF_ACQ_CAPTURE   = 3'b010,
		TPLF_ACQ_STREAMING = 3'b100
	} tplf_acq_state_t;

	typedef struct packed {
		logic [15:0] width;
		logic [15:0] height;
		logic [11:0] pix_fmt;
	} tplf_image_cfg_t;
endpackage

// File: design/tplf_ctl.sv
// Transport parameter lock, payload byte count and container format control.
// Assumes an APB master on pclk; internal sequencer updates arrive on pclk.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "tplf_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module tplf_ctl
	import tplf_pkg::*;
#(
	parameter int NUM_CH    = 2,
	parameter int HDR_WORDS = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        seq_update,
	input  wire logic [15:0] seq_width,
	input  wire logic [15:0] seq_height,
	output var  logic        capture_active,
	output var  logic        transfer_active,
	output var  logic        container_format_status,
	output var  logic        long_payload_active
);
	localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
	localparam int HW = (HDR_WORDS > 1) ? $clog2(HDR_WORDS) : 1;

	// Index widths and the header layout are sized for these ranges only
	if (NUM_CH < 1 || NUM_CH > 16 || HDR_WORDS != 4) begin : g_param_check
		$error("tplf_ctl: unsupported NUM_CH or HDR_WORDS");
	end

	logic                 transport_param_lock_q;
	tplf_group_t          lock_group_select_q;
	logic [4:0]           lock_group_state_q;
	tplf_image_cfg_t      img_q;
	logic                 line_scan_q;
	logic                 long_pl_q;
	tplf_fmt_mode_t       container_format_mode_q;
	tplf_test_sel_t       test_payload_format_sel_q;
	logic                 hdr_var_q;
	logic [CW-1:0]        stream_channel_index_q;
	logic [HW-1:0]        hdr_idx_q;
	logic [31:0]          buffer_byte_count_q [NUM_CH];
	logic [31:0]          preliminary_container_header_q [HDR_WORDS];
	logic                 fmt_status_q;
	tplf_acq_state_t      acq_q;
	logic [31:0]          prdata_q;

	// APB phases
	logic setup;
	logic wr_acc;
	logic unmapped;
	logic refuse;
	assign setup  = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;

	logic fd_locked, enc_locked, pw_locked, lp_locked;
	assign fd_locked  = transport_param_lock_q & lock_group_state_q[TPLF_GRP_FRAME_DIM];
	assign enc_locked = transport_param_lock_q & lock_group_state_q[TPLF_GRP_PIX_ENC];
	assign pw_locked  = transport_param_lock_q & lock_group_state_q[TPLF_GRP_PIX_WIDTH];
	assign lp_locked  = transport_param_lock_q & lock_group_state_q[TPLF_GRP_LONG_PL];

	logic [3:0] new_bpp;
	assign new_bpp = pwdata[`TPLF_PIX_BPP_LSB +: 4];

	always_comb begin
		unmapped = 1'b0;
		refuse   = 1'b0;
		case (paddr)
			`TPLF_OFF_LOCK, `TPLF_OFF_HDR_IDX: refuse = 1'b0;
			// selector, state, config frozen under lock; config may still change bits 1:0 with long payload group unlocked
			`TPLF_OFF_GRP_SEL, `TPLF_OFF_GRP_STATE, `TPLF_OFF_CFG:
				refuse = pwrite & transport_param_lock_q & ~(paddr == `TPLF_OFF_CFG
					&& !lp_locked && pwdata[8:4] == {hdr_var_q, test_payload_format_sel_q,
					container_format_mode_q});
			`TPLF_OFF_CHAN_IDX: refuse = 1'b0;
			`TPLF_OFF_WIDTH: refuse = pwrite & fd_locked;
			`TPLF_OFF_HEIGHT: refuse = pwrite & fd_locked & ~line_scan_q;
			// encoding change allowed if pixel width kept and encoding group unlocked
			`TPLF_OFF_PIX_FMT: refuse = pwrite & (enc_locked |
				(pw_locked & (new_bpp != img_q.pix_fmt[`TPLF_PIX_BPP_LSB +: 4])));
			`TPLF_OFF_CMD: refuse = pwrite & ~transport_param_lock_q & (pwdata[1:0] != 2'h0);
			`TPLF_OFF_BYTE_CNT, `TPLF_OFF_FMT_STAT, `TPLF_OFF_HDR_DATA, `TPLF_OFF_STATUS:
				refuse = pwrite;
			default: unmapped = 1'b1;
		endcase
	end

	logic wr_ok;
	// refused write leaves the value alone
	assign wr_ok   = wr_acc & ~refuse & ~unmapped;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & (refuse | unmapped);
	assign prdata  = prdata_q;

	// lock clears at reset; free writes at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			transport_param_lock_q <= 1'b0;
		end else if (wr_ok && paddr == `TPLF_OFF_LOCK) begin
			transport_param_lock_q <= pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_group_select_q <= TPLF_GRP_FRAME_DIM;
			lock_group_state_q  <= `TPLF_RST_GRP_STATE;
		end else if (wr_ok && paddr == `TPLF_OFF_GRP_SEL) begin
			lock_group_select_q <= (pwdata[2:0] > 3'h4) ? TPLF_GRP_DEV_SPEC
				: tplf_group_t'(pwdata[2:0]);
		end else if (wr_ok && paddr == `TPLF_OFF_GRP_STATE) begin
			lock_group_state_q[lock_group_select_q] <= pwdata[0];
		end
	end

	logic seq_blocked;
	// frame dimension group state also stops sequencer changes during capture
	assign seq_blocked = lock_group_state_q[TPLF_GRP_FRAME_DIM] & (acq_q != TPLF_ACQ_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			img_q.width   <= `TPLF_RST_WIDTH;
			img_q.height  <= `TPLF_RST_HEIGHT;
			img_q.pix_fmt <= `TPLF_RST_PIX_FMT;
		end else if (wr_ok && paddr == `TPLF_OFF_WIDTH) begin
			img_q.width <= pwdata[15:0];
		end else if (wr_ok && paddr == `TPLF_OFF_HEIGHT) begin
			img_q.height <= pwdata[15:0];
		end else if (wr_ok && paddr == `TPLF_OFF_PIX_FMT) begin
			img_q.pix_fmt <= pwdata[11:0];
		end else if (seq_update && !seq_blocked && !fd_locked) begin
			img_q.width  <= seq_width;
			img_q.height <= seq_height;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_scan_q               <= 1'b0;
			long_pl_q                 <= 1'b0;
			container_format_mode_q   <= TPLF_FMT_OFF;
			test_payload_format_sel_q <= TPLF_TEST_OFF;
			hdr_var_q                 <= 1'b0;
		end else if (wr_ok && paddr == `TPLF_OFF_CFG) begin
			line_scan_q <= pwdata[`TPLF_CFG_LINE_SCAN];
			long_pl_q   <= pwdata[`TPLF_CFG_LONG_PL];
			container_format_mode_q <= (pwdata[5:4] == 2'h3) ? TPLF_FMT_AUTO
				: tplf_fmt_mode_t'(pwdata[`TPLF_CFG_MODE_LSB +: 2]);
			test_payload_format_sel_q <= (pwdata[7:6] == 2'h3) ? TPLF_TEST_OFF
				: tplf_test_sel_t'(pwdata[`TPLF_CFG_TEST_LSB +: 2]);
			hdr_var_q <= pwdata[`TPLF_CFG_HDR_VAR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stream_channel_index_q <= '0;
			hdr_idx_q              <= '0;
		end else if (wr_ok && paddr == `TPLF_OFF_CHAN_IDX) begin
			stream_channel_index_q <= pwdata[CW-1:0];
		end else if (wr_ok && paddr == `TPLF_OFF_HDR_IDX) begin
			hdr_idx_q <= pwdata[HW-1:0];
		end
	end

	// format selection; test select keeps precedence; auto choice
	logic fmt_d;
	always_comb begin
		case (container_format_mode_q)
			TPLF_FMT_ON:   fmt_d = 1'b1;
			TPLF_FMT_AUTO: fmt_d = long_pl_q;
			default:       fmt_d = 1'b0;
		endcase
		if (test_payload_format_sel_q == TPLF_TEST_CONTAINER) begin
			fmt_d = 1'b1;
		end else if (test_payload_format_sel_q == TPLF_TEST_MULTIPART) begin
			fmt_d = 1'b0;
		end
	end

	// image bytes plus trailer, long payload and header bytes
	logic [35:0] pix_prod;
	logic [31:0] img_bytes;
	assign pix_prod  = img_q.width * img_q.height * img_q.pix_fmt[`TPLF_PIX_BPP_LSB +: 4];
	assign img_bytes = pix_prod[31:0] + `TPLF_TRAILER_BYTES
		+ (long_pl_q ? `TPLF_LONG_BYTES : 32'h0) + (fmt_d ? `TPLF_HDR_BYTES : 32'h0);

	// one count per channel; frozen while locked
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				buffer_byte_count_q[c] <= 32'h0;
			end else if (!transport_param_lock_q) begin
				buffer_byte_count_q[c] <= (c == 0) ? img_bytes : `TPLF_META_BYTES;
			end
		end
	end

	// header from live config; frozen with the count; max size
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fmt_status_q <= 1'b0;
			for (int i = 0; i < HDR_WORDS; i++) begin
				preliminary_container_header_q[i] <= 32'h0;
			end
		end else if (!transport_param_lock_q) begin
			fmt_status_q <= fmt_d;
			preliminary_container_header_q[0] <= {`TPLF_HDR_VERSION, 8'(NUM_CH), 8'h01};
			preliminary_container_header_q[1] <= img_bytes;
			preliminary_container_header_q[2] <= `TPLF_HDR_BYTES;
			preliminary_container_header_q[3] <= {img_q.width, img_q.height};
		end
	end

	assign container_format_status = fmt_status_q;
	assign long_payload_active     = long_pl_q;

	logic hdr_avail;
	// unavailable when layout varies or no container format
	assign hdr_avail = fmt_status_q & ~hdr_var_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_q <= TPLF_ACQ_IDLE;
		end else if (wr_ok && paddr == `TPLF_OFF_CMD) begin
			case (acq_q)
				TPLF_ACQ_IDLE: begin
					if (pwdata[`TPLF_CMD_CAPTURE]) begin
						acq_q <= pwdata[`TPLF_CMD_TRANSFER] ? TPLF_ACQ_STREAMING
							: TPLF_ACQ_CAPTURE;
					end
				end
				TPLF_ACQ_CAPTURE: begin
					if (pwdata[`TPLF_CMD_STOP]) begin
						acq_q <= TPLF_ACQ_IDLE;
					end else if (pwdata[`TPLF_CMD_TRANSFER]) begin
						acq_q <= TPLF_ACQ_STREAMING;
					end
				end
				TPLF_ACQ_STREAMING: begin
					if (pwdata[`TPLF_CMD_STOP]) begin
						acq_q <= TPLF_ACQ_IDLE;
					end
				end
				default: acq_q <= TPLF_ACQ_IDLE;
			endcase
		end
	end
	assign capture_active  = (acq_q != TPLF_ACQ_IDLE);
	assign transfer_active = (acq_q == TPLF_ACQ_STREAMING);

	// Read data is captured in the setup cycle so it leaves a flop
	logic [31:0] rd_d;
	always_comb begin
		case (paddr)
			`TPLF_OFF_LOCK:      rd_d = {31'h0, transport_param_lock_q};
			`TPLF_OFF_GRP_SEL:   rd_d = {29'h0, lock_group_select_q};
			`TPLF_OFF_GRP_STATE: rd_d = {31'h0, lock_group_state_q[lock_group_select_q]};
			`TPLF_OFF_WIDTH:     rd_d = {16'h0, img_q.width};
			`TPLF_OFF_HEIGHT:    rd_d = {16'h0, img_q.height};
			`TPLF_OFF_PIX_FMT:   rd_d = {20'h0, img_q.pix_fmt};
			`TPLF_OFF_CFG:       rd_d = {23'h0, hdr_var_q, test_payload_format_sel_q,
				container_format_mode_q, 2'h0, long_pl_q, line_scan_q};
			`TPLF_OFF_CHAN_IDX:  rd_d = 32'(stream_channel_index_q);
			`TPLF_OFF_BYTE_CNT:  rd_d = (32'(stream_channel_index_q) < NUM_CH)
				? buffer_byte_count_q[stream_channel_index_q] : 32'h0;
			`TPLF_OFF_FMT_STAT:  rd_d = {31'h0, fmt_status_q};
			`TPLF_OFF_HDR_IDX:   rd_d = 32'(hdr_idx_q);
			`TPLF_OFF_HDR_DATA:  rd_d = hdr_avail ? preliminary_container_header_q[hdr_idx_q]
				: 32'h0;
			`TPLF_OFF_STATUS:    rd_d = {29'h0, hdr_avail, transfer_active, capture_active};
			default:             rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (setup) begin
			prdata_q <= rd_d;
		end
	end

	// Checks
	lock_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == `TPLF_OFF_WIDTH && fd_locked |-> pslverr ##1 $stable(img_q.width))
		else $error("locked width write not refused");
	free_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == `TPLF_OFF_WIDTH && !transport_param_lock_q && !pslverr
		|=> img_q.width == $past(pwdata[15:0]))
		else $error("unlocked width write lost");
	line_height_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == `TPLF_OFF_HEIGHT && line_scan_q |-> !pslverr)
		else $error("line scan height refused");
	pix_width_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_acc && paddr == `TPLF_OFF_PIX_FMT && pw_locked && !enc_locked
		&& new_bpp == img_q.pix_fmt[11:8] |-> !pslverr)
		else $error("same width encoding refused");
	count_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		transport_param_lock_q && $past(transport_param_lock_q)
		|-> $stable(buffer_byte_count_q[0]))
		else $error("byte count moved under lock");
	hdr_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		transport_param_lock_q && $past(transport_param_lock_q)
		|-> $stable(preliminary_container_header_q[1]) && $stable(fmt_status_q))
		else $error("header moved under lock");
	test_prec_a: assert property (@(posedge pclk) disable iff (!presetn)
		!transport_param_lock_q && test_payload_format_sel_q == TPLF_TEST_CONTAINER
		|=> fmt_status_q || transport_param_lock_q)
		else $error("test select lost precedence");
	start_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		!transport_param_lock_q && acq_q == TPLF_ACQ_IDLE |=> acq_q == TPLF_ACQ_IDLE)
		else $error("capture began while unlocked");
	hdr_avail_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && paddr == `TPLF_OFF_HDR_DATA && hdr_var_q |=> prdata == 32'h0)
		else $error("variable header readable");
	seq_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		seq_update && seq_blocked && !(wr_ok && paddr inside {`TPLF_OFF_WIDTH,
		`TPLF_OFF_HEIGHT}) |=> $stable(img_q.width))
		else $error("sequencer changed locked size");

	lock_cycle_c: cover property (@(posedge pclk) disable iff (!presetn)
		!transport_param_lock_q ##1 transport_param_lock_q ##[1:20] transfer_active);
	refused_c: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr && wr_acc);
	auto_fmt_c: cover property (@(posedge pclk) disable iff (!presetn)
		container_format_mode_q == TPLF_FMT_AUTO && fmt_status_q);
endmodule

`default_nettype wire

// File: dv/tplf_host_model.sv
// Host receiver model: an APB master that configures and locks the block.
// Assumes a single pclk domain; the bench drives it through its tasks.
`include "tplf_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tplf_host_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata
);
	int tmo_cnt;
	initial begin
		tmo_cnt = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Request held until pready is sampled high or 64 edges pass; released address and data lines are inverted
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			tmo_cnt++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic lock_set(input logic v, output logic e);
		logic [31:0] q;
		xfer(1'b1, `TPLF_OFF_LOCK, {31'h0, v}, q, e);
	endtask
	// version decode, none assumed when unavailable
	function automatic logic [15:0] hdr_version(input logic [31:0] w0, input logic avail);
		return avail ? w0[31:16] : 16'h0000;
	endfunction
endmodule
`default_nettype wire

// File: dv/transport_param_lock_and_format_ctl_tb_top.sv
// Self-checking bench for the lock and container format control block.
// Assumes the host model drives APB; the bench drives the sequencer inputs.
`include "tplf_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module transport_param_lock_and_format_ctl_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rng, q;
	logic        seq_update, cap, xfr, fmt, lng, e, lp, ct;
	logic [15:0] seq_width, seq_height, w_m, h_m;
	logic [3:0]  b_m;
	logic [1:0]  m, t;
	logic [31:0] c0;
	int          miscompares, n_compared, i;

	tplf_ctl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .seq_update(seq_update),
		.seq_width(seq_width), .seq_height(seq_height), .capture_active(cap),
		.transfer_active(xfr), .container_format_status(fmt),
		.long_payload_active(lng));
	tplf_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		host.xfer(w, a, d, q, e);
		if (host.tmo_cnt != 0) begin
			chk(32'h1, 32'h0, "bus wait ran out");
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		xf(1'b1, a, d);
		chk({31'h0, e}, {31'h0, ee}, "write error flag");
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		xf(1'b0, a, 32'h0);
		chk(q, ex, "read data");
		chk({31'h0, e}, 32'h0, "read error flag");
	endtask
	task automatic grp(input logic [2:0] g, input logic s);
		wr(`TPLF_OFF_GRP_SEL, {29'h0, g}, 1'b0);
		wr(`TPLF_OFF_GRP_STATE, {31'h0, s}, 1'b0);
	endtask
	task automatic lk(input logic v);
		host.lock_set(v, e);
		chk({31'h0, e}, 32'h0, "lock write error");
	endtask
	task automatic seq_pulse(input logic [15:0] w, input logic [15:0] h);
		@(posedge pclk);
		seq_width <= w;
		seq_height <= h;
		seq_update <= 1'b1;
		@(posedge pclk);
		seq_update <= 1'b0;
	endtask
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function automatic logic [31:0] cnt(input logic l, input logic c);
		return 32'(w_m) * 32'(h_m) * 32'(b_m) + `TPLF_TRAILER_BYTES
			+ (l ? `TPLF_LONG_BYTES : 32'h0) + (c ? `TPLF_HDR_BYTES : 32'h0);
	endfunction
	function automatic logic fmt_of(input logic [1:0] md, input logic l, input logic [1:0] ts);
		if (ts == 2'h2)
			return 1'b1;
		if (ts == 2'h1)
			return 1'b0;
		return (md == 2'h0) ? 1'b0 : (md == 2'h1) ? 1'b1 : l;
	endfunction

	initial begin
		repeat (50000) @(posedge pclk);
		chk(32'h1, 32'h0, "run watchdog");
		final_report();
	end

	initial begin
		presetn = 1'b0;
		seq_update = 1'b0;
		seq_width = 16'h0;
		seq_height = 16'h0;
		rng = 32'h0000_a662;
		miscompares = 0;
		n_compared = 0;
		w_m = `TPLF_RST_WIDTH;
		h_m = `TPLF_RST_HEIGHT;
		b_m = 4'h1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(`TPLF_OFF_LOCK, 32'h0);
		rd(`TPLF_OFF_GRP_STATE, 32'h1);
		rd(`TPLF_OFF_WIDTH, {16'h0, w_m});
		rd(`TPLF_OFF_PIX_FMT, {20'h0, `TPLF_RST_PIX_FMT});
		rd(`TPLF_OFF_BYTE_CNT, cnt(1'b0, 1'b0));
		wr(`TPLF_OFF_BYTE_CNT, 32'h1, 1'b1);
		xf(1'b0, 8'h3c, 32'h0);
		chk({q[30:0], e}, 32'h1, "unmapped read");
		wr(`TPLF_OFF_CMD, 32'h1, 1'b1);
		wr(`TPLF_OFF_CMD, 32'h2, 1'b1);
		for (i = 0; i < 6; i++) begin
			w_m = 16'(xs() % 2000 + 1);
			h_m = 16'(xs() % 2000 + 1);
			b_m = 4'(xs() % 4 + 1);
			wr(`TPLF_OFF_WIDTH, {16'h0, w_m}, 1'b0);
			wr(`TPLF_OFF_HEIGHT, {16'h0, h_m}, 1'b0);
			wr(`TPLF_OFF_PIX_FMT, {20'h0, b_m, 8'h01}, 1'b0);
			rd(`TPLF_OFF_BYTE_CNT, cnt(1'b0, 1'b0));
		end
		wr(`TPLF_OFF_CHAN_IDX, 32'h1, 1'b0);
		rd(`TPLF_OFF_BYTE_CNT, `TPLF_META_BYTES);
		wr(`TPLF_OFF_CHAN_IDX, 32'h0, 1'b0);
		for (i = 0; i < 24; i++) begin
			m = i[1:0];
			lp = i[2];
			t = 2'(i / 8);
			ct = fmt_of(m, lp, t);
			wr(`TPLF_OFF_CFG, {24'h0, t, m, 2'b00, lp, 1'b0}, 1'b0);
			rd(`TPLF_OFF_FMT_STAT, {31'h0, ct});
			rd(`TPLF_OFF_BYTE_CNT, cnt(lp, ct));
			chk({30'h0, fmt, lng}, {30'h0, ct, lp}, "format outputs");
		end
		wr(`TPLF_OFF_CFG, 32'h10, 1'b0);
		rd(`TPLF_OFF_STATUS, 32'h4);
		ct = q[2];
		xf(1'b0, `TPLF_OFF_HDR_DATA, 32'h0);
		chk({16'h0, host.hdr_version(q, ct)}, {16'h0, `TPLF_HDR_VERSION}, "version");
		wr(`TPLF_OFF_HDR_IDX, 32'h2, 1'b0);
		rd(`TPLF_OFF_HDR_DATA, `TPLF_HDR_BYTES);
		wr(`TPLF_OFF_HDR_IDX, 32'h3, 1'b0);
		rd(`TPLF_OFF_HDR_DATA, {w_m, h_m});
		wr(`TPLF_OFF_CFG, 32'h110, 1'b0);
		rd(`TPLF_OFF_STATUS, 32'h0);
		ct = q[2];
		rd(`TPLF_OFF_HDR_DATA, 32'h0);
		chk({16'h0, host.hdr_version(q, ct)}, 32'h0, "version assumed");
		wr(`TPLF_OFF_CFG, 32'h10, 1'b0);
		for (i = 0; i < 10; i++) begin
			if (i < 5) begin
				grp(3'(i), i[0]);
			end else begin
				wr(`TPLF_OFF_GRP_SEL, 32'(i - 5), 1'b0);
				rd(`TPLF_OFF_GRP_STATE, 32'(i % 2 == 0));
			end
		end
		wr(`TPLF_OFF_GRP_SEL, 32'h7, 1'b0);
		rd(`TPLF_OFF_GRP_SEL, 32'h4);
		grp(3'h0, 1'b0);
		grp(3'h1, 1'b1);
		wr(`TPLF_OFF_HDR_IDX, 32'h1, 1'b0);
		c0 = cnt(1'b0, 1'b1);
		lk(1'b1);
		w_m = w_m + 16'h1;
		wr(`TPLF_OFF_WIDTH, {16'h0, w_m}, 1'b0);
		rd(`TPLF_OFF_BYTE_CNT, c0);
		rd(`TPLF_OFF_HDR_DATA, c0);
		wr(`TPLF_OFF_PIX_FMT, {20'h0, b_m, 8'h22}, 1'b1);
		rd(`TPLF_OFF_PIX_FMT, {20'h0, b_m, 8'h01});
		wr(`TPLF_OFF_GRP_SEL, 32'h0, 1'b1);
		lk(1'b0);
		rd(`TPLF_OFF_BYTE_CNT, cnt(1'b0, 1'b1));
		grp(3'h1, 1'b0);
		grp(3'h2, 1'b1);
		lk(1'b1);
		wr(`TPLF_OFF_PIX_FMT, {20'h0, b_m, 8'h5a}, 1'b0);
		wr(`TPLF_OFF_PIX_FMT, {20'h0, b_m + 4'h1, 8'h5a}, 1'b1);
		rd(`TPLF_OFF_PIX_FMT, {20'h0, b_m, 8'h5a});
		lk(1'b0);
		grp(3'h0, 1'b1);
		wr(`TPLF_OFF_CFG, 32'h11, 1'b0);
		lk(1'b1);
		wr(`TPLF_OFF_HEIGHT, {16'h0, h_m + 16'h1}, 1'b0);
		wr(`TPLF_OFF_WIDTH, 32'h5, 1'b1);
		lk(1'b0);
		wr(`TPLF_OFF_CFG, 32'h10, 1'b0);
		lk(1'b1);
		wr(`TPLF_OFF_HEIGHT, 32'h5, 1'b1);
		lk(1'b0);
		grp(3'h3, 1'b1);
		lk(1'b1);
		wr(`TPLF_OFF_CFG, 32'h12, 1'b1);
		lk(1'b0);
		grp(3'h3, 1'b0);
		lk(1'b1);
		wr(`TPLF_OFF_CFG, 32'h12, 1'b0);
		// Outputs move at the access edge itself; look once they have settled
		@(negedge pclk);
		chk({31'h0, lng}, 32'h1, "long payload output");
		wr(`TPLF_OFF_CMD, 32'h1, 1'b0);
		wr(`TPLF_OFF_CMD, 32'h2, 1'b0);
		@(negedge pclk);
		chk({30'h0, cap, xfr}, 32'h3, "capture outputs");
		seq_pulse(16'h0123, 16'h0045);
		rd(`TPLF_OFF_WIDTH, {16'h0, w_m});
		wr(`TPLF_OFF_CMD, 32'h4, 1'b0);
		@(negedge pclk);
		chk({30'h0, cap, xfr}, 32'h0, "stopped outputs");
		lk(1'b0);
		seq_pulse(16'h0123, 16'h0045);
		rd(`TPLF_OFF_WIDTH, 32'h0123);
		rd(`TPLF_OFF_HEIGHT, 32'h0045);
		final_report();
	end
endmodule
`default_nettype wire
